// ==== common/gpio_alert_pkg.sv ====
// Package: register addresses, field layouts and reset values of the GPIO/alarm block
package gpio_alert_pkg;

	// Register addresses
	localparam logic [3:0] WR_ALERT_ADDR    = 4'h3;
	localparam logic [3:0] WR_EXTENDED_ADDR = 4'hF;
	localparam logic [3:0] EXT_CFG_LO_ADDR  = 4'h0;
	localparam logic [3:0] EXT_CFG_HI_ADDR  = 4'h1;
	localparam logic [3:0] EXT_VALUES_ADDR  = 4'h2;
	localparam logic [4:0] RD_ALERT_ADDR    = 5'h03;
	localparam logic [4:0] RD_CFG_LO_ADDR   = 5'h1B;
	localparam logic [4:0] RD_CFG_HI_ADDR   = 5'h1C;
	localparam logic [4:0] RD_VALUES_ADDR   = 5'h1D;

	// Per-pin configuration nibble: bit positions
	localparam int CFG_ENABLE_BIT   = 0;
	localparam int CFG_DIR_BIT      = 1;
	localparam int CFG_POL_BIT      = 2;
	localparam int CFG_ALARM_BIT    = 3;
	localparam int CFG_NIBBLE_WIDTH = 4;

	// Alert register layout: 8 status bits then 4 enables
	localparam int ALERT_STATUS_LSB = 0;
	localparam int ALERT_ENABLE_LSB = 8;
	localparam int CHANNEL_COUNT    = 4;

	// Reset values: pins default to analog function except the fourth, which drives as an output; alarms masked
	localparam logic [7:0]  CFG_RESET    = 8'h00;
	localparam logic [7:0]  VALUES_RESET = 8'h00;
	localparam logic [11:0] ALERT_RESET  = 12'h000;

	// One register write as seen by this block
	typedef struct packed {
		logic        valid;
		logic [3:0]  addr;
		logic [11:0] data;
	} reg_write_s;

	// Limit events, a high and a low one per channel (aux, battery one, battery two, temperature)
	typedef struct packed {
		logic [3:0] high;
		logic [3:0] low;
	} limit_events_s;

endpackage : gpio_alert_pkg

// ==== hdl/gpio_alert_logic.sv ====
// GPIO pins with direction, polarity, function select and alarm logic
`timescale 1ns/10ps
`default_nettype none

module gpio_alert_logic #(
	parameter int PIN_COUNT = 4
) (
	// Clock and reset
	input  wire logic                          sys_clk_in,
	input  wire logic                          sys_rst_in,
	// Register write strobe from the serial interface
	input  wire gpio_alert_pkg::reg_write_s    reg_write_in,
	// Register read address and data back to the serial interface
	input  wire logic [4:0]                    read_addr_in,
	output var  logic [11:0]                   read_data_out,
	// Out-of-limit events from the measurement sequencer, one-cycle pulses
	input  wire gpio_alert_pkg::limit_events_s limit_events_in,
	// GPIO pins
	input  wire logic [PIN_COUNT-1:0]          gpio_pin_in,
	output var  logic [PIN_COUNT-1:0]          gpio_pin_out,
	output var  logic [PIN_COUNT-1:0]          gpio_pin_oe_n_out,
	// Alarm, active low
	output var  logic                          alarm_n_out
);

	// ==========================================================
	// Configuration helpers
	// ==========================================================
	function automatic logic cfg_bit(input logic [15:0] cfg, input int pin, input int pos);
		cfg_bit = cfg[pin*gpio_alert_pkg::CFG_NIBBLE_WIDTH + pos];
	endfunction : cfg_bit

	// Dedicated fourth pin has no function-select bit
	function automatic logic pin_enabled(input logic [15:0] cfg, input int pin);
		pin_enabled = (pin == PIN_COUNT-1) ? 1'b1 : cfg_bit(cfg, pin, gpio_alert_pkg::CFG_ENABLE_BIT);
	endfunction : pin_enabled

	// ==========================================================
	// Registers
	// ==========================================================
	logic [7:0]             gpio_cfg_lo;
	logic [7:0]             gpio_cfg_hi;
	logic [7:0]             gpio_pin_values;
	logic [11:0]            alert_limit_status_enable;
	logic [PIN_COUNT-1:0]   pin_sync_a;
	logic [PIN_COUNT-1:0]   pin_sync_b;
	logic [15:0]            cfg_all;
	logic                   ext_write;
	logic [3:0]             ext_addr;
	logic [7:0]             ext_data;
	logic [PIN_COUNT-1:0]   pin_is_input;
	logic [PIN_COUNT-1:0]   pin_is_output;
	logic [PIN_COUNT-1:0]   next_pin_data;
	logic [PIN_COUNT-1:0]   pin_alarm;
	logic [7:0]             chan_mask;
	logic [7:0]             limit_alarm;
	logic [11:0]            next_read_data;

	assign cfg_all   = {gpio_cfg_hi, gpio_cfg_lo};
	assign ext_write = reg_write_in.valid && reg_write_in.addr == gpio_alert_pkg::WR_EXTENDED_ADDR;
	assign ext_addr  = reg_write_in.data[11:8];
	assign ext_data  = reg_write_in.data[7:0];

	// ==========================================================
	// Input synchroniser
	// ==========================================================
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pin_sync_a <= '0;
			pin_sync_b <= '0;
		end else begin
			pin_sync_a <= gpio_pin_in;
			pin_sync_b <= pin_sync_a;
		end
	end

	// ==========================================================
	// Per-pin direction, polarity and alarm decode
	// ==========================================================
	always_comb begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			pin_is_input[i]  = pin_enabled(cfg_all, i) && cfg_bit(cfg_all, i, gpio_alert_pkg::CFG_DIR_BIT);
			pin_is_output[i] = pin_enabled(cfg_all, i) && !cfg_bit(cfg_all, i, gpio_alert_pkg::CFG_DIR_BIT);
			// Polarity 1 copies the level, polarity 0 inverts it
			next_pin_data[i] = pin_sync_b[i] ~^ cfg_bit(cfg_all, i, gpio_alert_pkg::CFG_POL_BIT);
			pin_alarm[i]     = pin_is_input[i] && gpio_pin_values[i]
				&& cfg_bit(cfg_all, i, gpio_alert_pkg::CFG_ALARM_BIT);
		end
	end

	// ==========================================================
	// Configuration registers
	// ==========================================================
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			gpio_cfg_lo <= gpio_alert_pkg::CFG_RESET;
			gpio_cfg_hi <= gpio_alert_pkg::CFG_RESET;
		end else if (ext_write) begin
			if (ext_addr == gpio_alert_pkg::EXT_CFG_LO_ADDR) begin
				gpio_cfg_lo <= ext_data;
			end
			if (ext_addr == gpio_alert_pkg::EXT_CFG_HI_ADDR) begin
				gpio_cfg_hi <= ext_data;
			end
		end
	end

	// ==========================================================
	// Data register: inputs follow pins, outputs take host writes
	// ==========================================================
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			gpio_pin_values <= gpio_alert_pkg::VALUES_RESET;
		end else begin
			for (int i = 0; i < PIN_COUNT; i++) begin
				if (pin_is_input[i]) begin
					gpio_pin_values[i] <= next_pin_data[i];
				end else if (ext_write && ext_addr == gpio_alert_pkg::EXT_VALUES_ADDR) begin
					gpio_pin_values[i] <= ext_data[i];
				end
			end
		end
	end

	// ==========================================================
	// Pin drivers
	// ==========================================================
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			gpio_pin_out      <= '0;
			gpio_pin_oe_n_out <= '1;
		end else begin
			for (int i = 0; i < PIN_COUNT; i++) begin
				// Polarity 1 drives data as is, polarity 0 drives it inverted
				gpio_pin_out[i]      <= gpio_pin_values[i] ~^ cfg_bit(cfg_all, i, gpio_alert_pkg::CFG_POL_BIT);
				gpio_pin_oe_n_out[i] <= !pin_is_output[i];
			end
		end
	end

	// ==========================================================
	// Alert status and enable register
	// ==========================================================
	// Set wins over a host clear arriving in the same cycle
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			alert_limit_status_enable <= gpio_alert_pkg::ALERT_RESET;
		end else begin
			if (reg_write_in.valid && reg_write_in.addr == gpio_alert_pkg::WR_ALERT_ADDR) begin
				// Status bits can only be cleared by writing 0; enables are plain
				alert_limit_status_enable <= {reg_write_in.data[11:8],
					alert_limit_status_enable[7:0] & reg_write_in.data[7:0]
					| {limit_events_in.high, limit_events_in.low}};
			end else begin
				alert_limit_status_enable[7:0] <= alert_limit_status_enable[7:0]
					| {limit_events_in.high, limit_events_in.low};
			end
		end
	end

	// ==========================================================
	// Alarm output
	// ==========================================================
	assign chan_mask   = {2{alert_limit_status_enable[gpio_alert_pkg::ALERT_ENABLE_LSB +: gpio_alert_pkg::CHANNEL_COUNT]}};
	assign limit_alarm = alert_limit_status_enable[7:0] & chan_mask;

	// Level output, held for as long as any source stays active
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			alarm_n_out <= 1'b1;
		end else begin
			alarm_n_out <= !(|pin_alarm || |limit_alarm);
		end
	end

	// ==========================================================
	// Read-back
	// ==========================================================
	always_comb begin
		case (read_addr_in)
			gpio_alert_pkg::RD_ALERT_ADDR:  next_read_data = alert_limit_status_enable;
			gpio_alert_pkg::RD_CFG_LO_ADDR: next_read_data = {4'h0, gpio_cfg_lo};
			gpio_alert_pkg::RD_CFG_HI_ADDR: next_read_data = {4'h0, gpio_cfg_hi};
			gpio_alert_pkg::RD_VALUES_ADDR: next_read_data = {4'h0, gpio_pin_values};
			default:                        next_read_data = 12'h000;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			read_data_out <= 12'h000;
		end else begin
			read_data_out <= next_read_data;
		end
	end

endmodule : gpio_alert_logic
`default_nettype wire

// ==== tb/gpio_alert_sva.sv ====
// Checker: port-level assertions of the GPIO and alarm block
`timescale 1ns/10ps
`default_nettype none
module gpio_alert_sva #(parameter int PIN_COUNT = 4) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire gpio_alert_pkg::reg_write_s reg_write_in,
	input wire logic [4:0] read_addr_in,
	input wire logic [11:0] read_data_out,
	input wire gpio_alert_pkg::limit_events_s limit_events_in,
	input wire logic [PIN_COUNT-1:0] gpio_pin_in,
	input wire logic [PIN_COUNT-1:0] gpio_pin_out,
	input wire logic [PIN_COUNT-1:0] gpio_pin_oe_n_out,
	input wire logic alarm_n_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence alert_read;
		read_addr_in == 5'h03;
	endsequence
	// Same config read twice, no write: pin drive has settled
	sequence cfg_held;
		$past(read_addr_in) == 5'h1C && $past(read_addr_in, 2) == 5'h1C && $stable(read_data_out) && !reg_write_in.valid;
	endsequence
	a_limit_sets_status: assert property (
		(|limit_events_in) ##0 alert_read ##1 alert_read
		|=> (read_data_out[7:0] & $past(limit_events_in, 2)) == $past(limit_events_in, 2))
		else $error("limit event left no status");
	a_status_write_clears: assert property (
		(reg_write_in.valid && reg_write_in.addr == 4'h3) ##0 alert_read ##1 alert_read
		|=> read_data_out[11:8] == $past(reg_write_in.data[11:8], 2)
		&& (read_data_out[7:0] & ~$past(reg_write_in.data[7:0], 2) & ~$past(limit_events_in, 2)) == 8'h00)
		else $error("alert write misapplied");
	a_limit_drives_alarm: assert property (
		$past(read_addr_in) == 5'h03 && |((read_data_out[7:4] | read_data_out[3:0]) & read_data_out[11:8])
		|-> !alarm_n_out) else $error("enabled limit without alarm");
	a_gpio_read_width: assert property (
		$past(read_addr_in) >= 5'h1B && $past(read_addr_in) <= 5'h1D |-> read_data_out[11:8] == 4'h0)
		else $error("gpio read wider than 8 bits");
	a_null_read_zero: assert property (
		$past(read_addr_in) == 5'h00 |-> read_data_out == 12'h000) else $error("null read not zero");
	a_last_pin_drive: assert property (
		cfg_held |-> gpio_pin_oe_n_out[PIN_COUNT-1] == read_data_out[5]) else $error("last pin drive wrong");
	a_pin_two_drive: assert property (
		cfg_held |-> gpio_pin_oe_n_out[PIN_COUNT-2] == !(read_data_out[0] && !read_data_out[1]))
		else $error("pin two drive wrong");
	a_alarm_holds: assert property (
		(!alarm_n_out && !reg_write_in.valid && $stable(gpio_pin_in)) [*5] |=> !alarm_n_out)
		else $error("alarm released without cause");
endmodule : gpio_alert_sva
bind gpio_alert_logic gpio_alert_sva #(.PIN_COUNT(PIN_COUNT)) gpio_alert_sva_i (.sys_clk_in(sys_clk_in),
	.sys_rst_in(sys_rst_in), .reg_write_in(reg_write_in), .read_addr_in(read_addr_in), .read_data_out(read_data_out),
	.limit_events_in(limit_events_in), .gpio_pin_in(gpio_pin_in), .gpio_pin_out(gpio_pin_out),
	.gpio_pin_oe_n_out(gpio_pin_oe_n_out), .alarm_n_out(alarm_n_out));
`default_nettype wire

// ==== tb/pin_world.sv ====
// Pin-side model: outside levels meeting the block's pin drivers
`timescale 1ns/10ps
`default_nettype none
module pin_world (
	input wire logic [3:0] pin_level_in,
	input wire logic [3:0] pin_oe_n_in,
	input wire logic [3:0] ext_level_in,
	output logic [3:0] pin_seen_out
);
	// Driven pins read back their own level, released ones the outside level
	assign pin_seen_out = (pin_oe_n_in & ext_level_in) | (~pin_oe_n_in & pin_level_in);
endmodule : pin_world
`default_nettype wire

// ==== tb/tb_gpio_alert_logic.sv ====
// Testbench: pins, registers, limits and alarm of the GPIO block
`timescale 1ns/10ps
`default_nettype none
module tb_gpio_alert_logic;
	logic sys_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	gpio_alert_pkg::reg_write_s reg_write_in = '0;
	gpio_alert_pkg::limit_events_s limit_events_in = '0;
	logic [4:0] read_addr_in = 5'h00;
	logic [11:0] read_data_out, notes[$];
	logic [3:0] gpio_pin_in, gpio_pin_out, gpio_pin_oe_n_out, ext = 4'h0, n, e;
	logic alarm_n_out;
	logic [1:0] go = 2'h0, go_d = 2'h0;
	logic [31:0] lfsr = 32'h844E;
	int fail_count = 0, checked = 0, cycles = 0;
	gpio_alert_logic gpio_alert_logic_i (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_write_in(reg_write_in),
		.read_addr_in(read_addr_in), .read_data_out(read_data_out), .limit_events_in(limit_events_in),
		.gpio_pin_in(gpio_pin_in), .gpio_pin_out(gpio_pin_out), .gpio_pin_oe_n_out(gpio_pin_oe_n_out),
		.alarm_n_out(alarm_n_out));
	pin_world pin_world_i (.pin_level_in(gpio_pin_out), .pin_oe_n_in(gpio_pin_oe_n_out), .ext_level_in(ext),
		.pin_seen_out(gpio_pin_in));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	task cmp(input logic [11:0] x, input logic [11:0] a);
		checked++;
		if (a !== x) begin
			fail_count++;
			$display("FAIL %0t exp %h got %h", $time, x, a);
		end
	endtask : cmp
	task cmp_read(input logic [11:0] x);
		cmp(x, read_data_out);
	endtask : cmp_read
	task cmp_drive(input logic [11:0] x);
		cmp(x, {4'h0, gpio_pin_oe_n_out, gpio_pin_out & ~gpio_pin_oe_n_out});
	endtask : cmp_drive
	task cmp_alarm(input logic [11:0] x);
		cmp(x, {11'h0, alarm_n_out});
	endtask : cmp_alarm
	task stop_test;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	task wr(input logic [3:0] a, input logic [11:0] d);
		@(posedge sys_clk_in);
		#1 reg_write_in = {1'b1, a, d};
		@(posedge sys_clk_in);
		#1 reg_write_in.valid = 1'b0;
	endtask : wr
	task cfg(input logic [3:0] v);
		wr(4'hF, {4'h0, v, v});
		wr(4'hF, {4'h1, v, v});
	endtask : cfg
	task pulse(input logic [7:0] v);
		@(posedge sys_clk_in);
		#1 limit_events_in = v;
		@(posedge sys_clk_in);
		#1 limit_events_in = '0;
	endtask : pulse
	// Kind 1 read data, 2 pin drive, 3 alarm
	task chk(input logic [1:0] k, input logic [4:0] a, input logic [11:0] x);
		@(posedge sys_clk_in);
		#1 read_addr_in = (k == 2'h1) ? a : read_addr_in;
		notes.push_back(x);
		go = k;
		@(posedge sys_clk_in);
		#1 go = 2'h0;
	endtask : chk
	task quiet_check;
		repeat (2) @(posedge sys_clk_in);
		chk(2'h1, 5'h1C, 12'h000);
		chk(2'h1, 5'h00, 12'h000);
		chk(2'h2, 5'h00, 12'h078);
		chk(2'h3, 5'h00, 12'h001);
	endtask : quiet_check
	initial forever #10 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) begin
		go_d <= go;
		cycles <= cycles + 1;
		case (go_d)
			2'h1: cmp_read(notes.pop_front());
			2'h2: cmp_drive(notes.pop_front());
			2'h3: cmp_alarm(notes.pop_front());
			default: ;
		endcase
		// Timeout last, so nothing runs after the run is ended
		if (cycles == 2000) begin
			fail_count++;
			stop_test();
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk_in);
		#1 sys_rst_in = 1'b0;
		quiet_check();
		for (int i = 0; i < 2; i++) begin
			lfsr = nxt(lfsr);
			cfg({lfsr[4], i[0], 2'b01});
			wr(4'hF, {4'h2, 4'h0, lfsr[11:8]});
			chk(2'h1, gpio_alert_pkg::RD_CFG_HI_ADDR, {4'h0, lfsr[4], i[0], 2'b01, lfsr[4], i[0], 2'b01});
			chk(2'h1, gpio_alert_pkg::RD_VALUES_ADDR, {8'h00, lfsr[11:8]});
			chk(2'h2, 5'h00, {8'h00, i[0] ? lfsr[11:8] : ~lfsr[11:8]});
			chk(2'h3, 5'h00, 12'h001);
		end
		for (int i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			e = lfsr[3:0] | 4'h1;
			n = {i[0], i[1], 2'b11};
			ext = i[1] ? e : ~e;
			cfg(n);
			wr(4'hF, {4'h2, 4'h0, ~e});
			repeat (5) @(posedge sys_clk_in);
			chk(2'h1, gpio_alert_pkg::RD_VALUES_ADDR, {8'h00, e});
			chk(2'h2, 5'h00, 12'h0F0);
			chk(2'h3, 5'h00, {11'h0, ~i[0]});
			if (i == 1)
				cfg(n & 4'h7);
			else
				ext = i[1] ? 4'h0 : 4'hF;
			repeat (5) @(posedge sys_clk_in);
			chk(2'h3, 5'h00, 12'h001);
		end
		cfg(4'h0);
		wr(4'hF, 12'h200);
		quiet_check();
		lfsr = nxt(lfsr);
		wr(4'h3, 12'hF00);
		read_addr_in = 5'h03;
		pulse(lfsr[7:0] | 8'h01);
		chk(2'h1, 5'h03, {4'hF, lfsr[7:0] | 8'h01});
		chk(2'h3, 5'h00, 12'h000);
		wr(4'h3, 12'hF00);
		chk(2'h1, 5'h03, 12'hF00);
		chk(2'h3, 5'h00, 12'h001);
		pulse(lfsr[7:0] | 8'h01);
		wr(4'h3, 12'h0FF);
		chk(2'h1, 5'h03, {4'h0, lfsr[7:0] | 8'h01});
		chk(2'h3, 5'h00, 12'h001);
		stop_test();
	end
endmodule : tb_gpio_alert_logic
`default_nettype wire
